// *** hdl/sflt_top.sv ***
// Contract
// - Bytes travel most significant bit first
// - Order: length, payload unit, checksum
// - Payload unit starts with control byte
// - Header is one byte of payload length
// - CRC16 x16+x12+x5+1, init all ones
// - Whole frame never exceeds negotiated MTU
// - MTU is smaller of both, both directions
// - Filler allowed while total stays within MTU
// - Idle slave returns 0xFF filler
// - Slave frame starts on first MISO byte
// - Filler after checksum until access ends
// - Second access resumes after last byte
// - Length byte first; one frame per access
// - Access request precedes every frame
// - Split slave frame stays within MTU
// - Request pulse meets minimum width
`timescale 1ns/1ns
`default_nettype none
`include "sflt_regs.svh"

module sflt_top
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_n_o,
    output logic spi_req_o,
    input wire logic [7:0] master_mtu_i,
    input wire logic [7:0] slave_mtu_i,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_len_i,
    input wire logic tx_byte_valid_i,
    input wire logic [7:0] tx_byte_i,
    output logic tx_busy_o,
    output logic tx_err_o,
    output logic tx_done_o,
    input wire logic [7:0] rx_rd_addr_i,
    output logic [7:0] rx_rd_data_o,
    output logic rx_done_o,
    output logic rx_err_o,
    output logic [7:0] rx_len_o
);
    import sflt_pkg::*;

    // Link domain state.
    logic [2:0] bit_cnt_r;
    logic [7:0] byte_cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] rx_hold_r;
    logic rx_tgl_r;
    logic first_r;
    logic [7:0] tx_sh_r;
    logic miso_r;
    logic [7:0] link_rdata;
    logic [8:0] link_idx;
    logic [7:0] next_byte;

    // System domain state.
    logic cs_s1_r, cs_s2_r, cs_s3_r, cs_s4_r;
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic byte_ev;
    logic acc_end;
    logic [7:0] acc_cnt_r;
    logic [7:0] mtu_r;
    sflt_build_type bld_r;
    logic [7:0] len_r;
    logic [7:0] wcnt_r;
    logic tx_live_r;
    logic [7:0] start_idx_r;
    logic [7:0] total_r;
    logic [7:0] first_byte_r;
    logic [7:0] ref_rdata;
    logic [7:0] req_cnt_r;
    logic tx_we;
    logic [7:0] tx_waddr;
    logic [7:0] tx_wdata;
    logic tx_crc_init;
    logic tx_crc_en;
    logic [15:0] tx_crc;
    logic [8:0] sent_sum;
    logic tx_len_ok;
    sflt_rx_type rx_r;
    logic [7:0] rcnt_r;
    logic [7:0] crc_hi_r;
    logic rx_len_ok;
    logic rx_crc_init;
    logic rx_crc_en;
    logic [15:0] rx_crc;

    // Link side: bit and byte counting, cleared by the frame's own select.
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 8'h00;
            rx_sh_r <= 8'h00;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r <= {rx_sh_r[6:0], spi_mosi_i};
            if (bit_cnt_r == `SFLT_LAST_BIT && byte_cnt_r != 8'hff)
                byte_cnt_r <= byte_cnt_r + 8'h01;
        end
    end

    // Each whole byte is held stable and announced by a toggle.
    always_ff @(posedge spi_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_hold_r <= 8'h00;
            rx_tgl_r <= 1'b0;
        end
        else if (bit_cnt_r == `SFLT_LAST_BIT)
        begin
            rx_hold_r <= {rx_sh_r[6:0], spi_mosi_i};
            rx_tgl_r <= ~rx_tgl_r;
        end
    end

    assign link_idx = {1'b0, start_idx_r} + {1'b0, byte_cnt_r};
    // Past the frame end, or with nothing to send, the line carries filler.
    assign next_byte = (tx_live_r && link_idx < {1'b0, total_r})
                       ? link_rdata : `SFLT_IDLE_FILL;

    // Bits change on the falling edge so the master samples on the rising.
    always_ff @(negedge spi_clk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            first_r <= 1'b1;
            miso_r <= 1'b1;
            tx_sh_r <= `SFLT_IDLE_FILL;
        end
        else if (first_r)
        begin
            first_r <= 1'b0;
            miso_r <= first_byte_r[6];
            tx_sh_r <= {first_byte_r[5:0], 2'b11};
        end
        else if (bit_cnt_r == 3'h0)
        begin
            miso_r <= next_byte[7];
            tx_sh_r <= {next_byte[6:0], 1'b1};
        end
        else
        begin
            miso_r <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
        end
    end

    // The first bit must be on the line before any clock edge arrives, so
    // it comes from the byte prepared while the select was idle.
    assign spi_miso_o = first_r ? first_byte_r[7] : miso_r;
    assign spi_miso_oe_n_o = spi_cs_n_i;

    // System side synchronisers; the fourth select stage gives the last
    // byte toggle time to land before the access is closed.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            cs_s4_r <= 1'b1;
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end
        else
        begin
            cs_s1_r <= spi_cs_n_i;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            cs_s4_r <= cs_s3_r;
            tgl_s1_r <= rx_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    assign byte_ev = tgl_s2_r ^ tgl_s3_r;
    assign acc_end = cs_s3_r & ~cs_s4_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || acc_end)
            acc_cnt_r <= 8'h00;
        else if (byte_ev && acc_cnt_r != 8'hff)
            acc_cnt_r <= acc_cnt_r + 8'h01;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            mtu_r <= 8'h00;
        else
            mtu_r <= (master_mtu_i < slave_mtu_i)
                     ? master_mtu_i : slave_mtu_i;
    end

    assign tx_len_ok = tx_len_i != 8'h00
                       && ({1'b0, tx_len_i} + `SFLT_FRAME_OVERHEAD)
                          <= {1'b0, mtu_r};
    assign sent_sum = {1'b0, start_idx_r} + {1'b0, acc_cnt_r};

    // Frame image in memory: length, payload unit, checksum high, low.
    always_comb
    begin
        tx_we = 1'b0;
        tx_waddr = `SFLT_LEN_IDX;
        tx_wdata = tx_len_i;
        tx_crc_init = 1'b0;
        tx_crc_en = 1'b0;
        case (bld_r)
            BLD_IDLE:
            begin
                tx_we = tx_start_i && tx_len_ok;
                tx_crc_init = tx_we;
                tx_crc_en = tx_we;
            end
            BLD_LOAD:
            begin
                tx_we = tx_byte_valid_i;
                tx_waddr = wcnt_r + `SFLT_PAYLOAD_IDX;
                tx_wdata = tx_byte_i;
                tx_crc_en = tx_byte_valid_i;
            end
            BLD_CRC_HI:
            begin
                tx_we = 1'b1;
                tx_waddr = len_r + `SFLT_PAYLOAD_IDX;
                tx_wdata = tx_crc[15:8];
            end
            BLD_CRC_LO:
            begin
                tx_we = 1'b1;
                tx_waddr = len_r + 8'h02;
                tx_wdata = tx_crc[7:0];
            end
            default:
            begin
                tx_we = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            bld_r <= BLD_IDLE;
            len_r <= 8'h00;
            wcnt_r <= 8'h00;
            tx_live_r <= 1'b0;
            start_idx_r <= 8'h00;
            total_r <= 8'h00;
            tx_err_o <= 1'b0;
            tx_done_o <= 1'b0;
            tx_busy_o <= 1'b0;
        end
        else
        begin
            tx_err_o <= 1'b0;
            tx_done_o <= 1'b0;
            tx_busy_o <= bld_r != BLD_IDLE;
            case (bld_r)
                BLD_IDLE:
                    if (tx_start_i)
                    begin
                        if (tx_len_ok)
                        begin
                            len_r <= tx_len_i;
                            wcnt_r <= 8'h00;
                            bld_r <= BLD_LOAD;
                        end
                        else
                            tx_err_o <= 1'b1;
                    end
                BLD_LOAD:
                    if (tx_byte_valid_i)
                    begin
                        wcnt_r <= wcnt_r + 8'h01;
                        if (wcnt_r == len_r - 8'h01)
                            bld_r <= BLD_CRC_HI;
                    end
                BLD_CRC_HI:
                    bld_r <= BLD_CRC_LO;
                BLD_CRC_LO:
                    bld_r <= BLD_WAIT;
                BLD_WAIT:
                    // A frame goes live only between accesses.
                    if (cs_s2_r && cs_s4_r)
                    begin
                        tx_live_r <= 1'b1;
                        start_idx_r <= `SFLT_LEN_IDX;
                        total_r <= 8'({1'b0, len_r} + `SFLT_FRAME_OVERHEAD);
                        bld_r <= BLD_LIVE;
                    end
                BLD_LIVE:
                    if (acc_end)
                    begin
                        if (sent_sum >= {1'b0, total_r})
                        begin
                            tx_live_r <= 1'b0;
                            tx_done_o <= 1'b1;
                            bld_r <= BLD_IDLE;
                        end
                        else
                            start_idx_r <= sent_sum[7:0];
                    end
                default:
                    bld_r <= BLD_IDLE;
            endcase
        end
    end

    // Access request pulse of at least the minimum width.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            req_cnt_r <= 8'h00;
            spi_req_o <= 1'b0;
        end
        else if (bld_r == BLD_WAIT && cs_s2_r && cs_s4_r)
        begin
            req_cnt_r <= 8'(`SFLT_REQ_PULSE_CYC);
            spi_req_o <= 1'b1;
        end
        else
        begin
            if (req_cnt_r != 8'h00)
                req_cnt_r <= req_cnt_r - 8'h01;
            spi_req_o <= req_cnt_r > 8'h01;
        end
    end

    // The first byte only changes while the select is idle, so the link
    // side may read it without a synchroniser.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            first_byte_r <= `SFLT_IDLE_FILL;
        else if (cs_s2_r && cs_s4_r)
        begin
            if (!tx_live_r)
                first_byte_r <= `SFLT_IDLE_FILL;
            else if (start_idx_r == `SFLT_LEN_IDX)
                first_byte_r <= len_r;
            else
                first_byte_r <= ref_rdata;
        end
    end

    // Reception of a master frame, parsed from its own length byte.
    assign rx_len_ok = rx_hold_r != 8'h00
                       && ({1'b0, rx_hold_r} + `SFLT_FRAME_OVERHEAD)
                          <= {1'b0, mtu_r};
    assign rx_crc_init = byte_ev && rx_r == RX_LEN;
    assign rx_crc_en = byte_ev && (rx_r == RX_LEN || rx_r == RX_DATA);

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rx_r <= RX_LEN;
            rcnt_r <= 8'h00;
            crc_hi_r <= 8'h00;
            rx_len_o <= 8'h00;
            rx_done_o <= 1'b0;
            rx_err_o <= 1'b0;
        end
        else
        begin
            rx_done_o <= 1'b0;
            rx_err_o <= 1'b0;
            if (acc_end)
                rx_r <= RX_LEN;
            else if (byte_ev)
            begin
                case (rx_r)
                    RX_LEN:
                        if (rx_hold_r == `SFLT_IDLE_FILL)
                            rx_r <= RX_SKIP;
                        else if (!rx_len_ok)
                        begin
                            rx_err_o <= 1'b1;
                            rx_r <= RX_SKIP;
                        end
                        else
                        begin
                            rx_len_o <= rx_hold_r;
                            rcnt_r <= 8'h00;
                            rx_r <= RX_DATA;
                        end
                    RX_DATA:
                    begin
                        rcnt_r <= rcnt_r + 8'h01;
                        if (rcnt_r == rx_len_o - 8'h01)
                            rx_r <= RX_CRC_HI;
                    end
                    RX_CRC_HI:
                    begin
                        crc_hi_r <= rx_hold_r;
                        rx_r <= RX_CRC_LO;
                    end
                    RX_CRC_LO:
                    begin
                        if ({crc_hi_r, rx_hold_r} == rx_crc)
                            rx_done_o <= 1'b1;
                        else
                            rx_err_o <= 1'b1;
                        rx_r <= RX_SKIP;
                    end
                    default:
                        rx_r <= RX_SKIP;
                endcase
            end
        end
    end

    sflt_crc16 u_tx_crc
    (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .init_i(tx_crc_init),
        .en_i(tx_crc_en),
        .data_i(tx_wdata),
        .crc_o(tx_crc)
    );

    sflt_crc16 u_rx_crc
    (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .init_i(rx_crc_init),
        .en_i(rx_crc_en),
        .data_i(rx_hold_r),
        .crc_o(rx_crc)
    );

    // Two copies of the frame image: one read by the link clock, one read
    // by the system clock to fetch the resume byte.
    sflt_frame_mem u_tx_link_mem
    (
        .wclk_i(ref_clk_i),
        .we_i(tx_we),
        .waddr_i(tx_waddr),
        .wdata_i(tx_wdata),
        .rclk_i(spi_clk_i),
        .raddr_i(8'(link_idx + 9'h001)),
        .rdata_o(link_rdata)
    );

    sflt_frame_mem u_tx_ref_mem
    (
        .wclk_i(ref_clk_i),
        .we_i(tx_we),
        .waddr_i(tx_waddr),
        .wdata_i(tx_wdata),
        .rclk_i(ref_clk_i),
        .raddr_i(start_idx_r),
        .rdata_o(ref_rdata)
    );

    sflt_frame_mem u_rx_mem
    (
        .wclk_i(ref_clk_i),
        .we_i(byte_ev && rx_r == RX_DATA && !acc_end),
        .waddr_i(rcnt_r),
        .wdata_i(rx_hold_r),
        .rclk_i(ref_clk_i),
        .raddr_i(rx_rd_addr_i),
        .rdata_o(rx_rd_data_o)
    );
endmodule

`default_nettype wire

// *** hdl/sflt_regs.svh ***
`ifndef SFLT_REGS_SVH
`define SFLT_REGS_SVH

`define SFLT_IDLE_FILL 8'hff
`define SFLT_CRC_INIT 16'hffff
`define SFLT_CRC_POLY 16'h1021
`define SFLT_FRAME_OVERHEAD 9'h003
`define SFLT_LEN_IDX 8'h00
`define SFLT_PAYLOAD_IDX 8'h01
`define SFLT_LAST_BIT 3'h7
`define SFLT_MEM_AW 8
`define SFLT_MEM_DEPTH 256
`define SFLT_CLK_MHZ 50
`define SFLT_REQ_PULSE_NS 1000
`define SFLT_REQ_PULSE_CYC ((`SFLT_REQ_PULSE_NS * `SFLT_CLK_MHZ + 999) / 1000)

`endif

// *** hdl/sflt_pkg.sv ***
package sflt_pkg;

    typedef enum logic [2:0] {
        BLD_IDLE,
        BLD_LOAD,
        BLD_CRC_HI,
        BLD_CRC_LO,
        BLD_WAIT,
        BLD_LIVE
    } sflt_build_type;

    typedef enum logic [2:0] {
        RX_LEN,
        RX_DATA,
        RX_CRC_HI,
        RX_CRC_LO,
        RX_SKIP
    } sflt_rx_type;

endpackage

// *** hdl/sflt_crc16.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sflt_regs.svh"

module sflt_crc16
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic init_i,
    input wire logic en_i,
    input wire logic [7:0] data_i,
    output logic [15:0] crc_o
);
    logic [15:0] base;
    logic [15:0] step;

    always_comb
    begin
        base = init_i ? `SFLT_CRC_INIT : crc_o;
        step = base;
        for (int i = 7; i >= 0; i--)
        begin
            if (step[15] ^ data_i[i])
                step = {step[14:0], 1'b0} ^ `SFLT_CRC_POLY;
            else
                step = {step[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            crc_o <= `SFLT_CRC_INIT;
        else if (en_i)
            crc_o <= step;
        else if (init_i)
            crc_o <= `SFLT_CRC_INIT;
    end
endmodule

`default_nettype wire

// *** hdl/sflt_frame_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sflt_regs.svh"

module sflt_frame_mem
(
    input wire logic wclk_i,
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rclk_i,
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [`SFLT_MEM_DEPTH];

    always_ff @(posedge wclk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
    end

    always_ff @(posedge rclk_i)
    begin
        rdata_o <= mem[raddr_i];
    end
endmodule

`default_nettype wire

// *** testbench/sflt_top_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module sflt_top_chk
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe_n_o,
    input wire logic spi_req_o,
    input wire logic [7:0] master_mtu_i,
    input wire logic [7:0] slave_mtu_i,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_len_i,
    input wire logic tx_busy_o,
    input wire logic tx_err_o,
    input wire logic tx_done_o,
    input wire logic rx_done_o,
    input wire logic rx_err_o
);
    logic [7:0] req_cnt_r;
    logic [7:0] mtu_min;
    logic ok_len;
    assign mtu_min = (master_mtu_i < slave_mtu_i) ? master_mtu_i : slave_mtu_i;
    assign ok_len = (tx_len_i != 8'h00)
        && ({1'b0, tx_len_i} + 9'h003 <= {1'b0, mtu_min});
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !spi_req_o)
            req_cnt_r <= 8'h00;
        else if (req_cnt_r != 8'hff)
            req_cnt_r <= req_cnt_r + 8'h01;
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    a_oe_tracks_cs: assert property (spi_miso_oe_n_o == spi_cs_n_i)
        else $error("miso enable does not follow select");
    a_req_width: assert property ($fell(spi_req_o) |-> req_cnt_r == 8'h32)
        else $error("request pulse width wrong");
    a_req_idle_cs: assert property ($rose(spi_req_o) |-> spi_cs_n_i)
        else $error("request raised during an access");
    a_start_refused: assert property (tx_start_i && !tx_busy_o && !ok_len
        && $stable(master_mtu_i) && $stable(slave_mtu_i)
        |=> tx_err_o && !tx_busy_o)
        else $error("oversize frame not refused");
    a_start_taken: assert property (tx_start_i && !tx_busy_o && ok_len
        && $stable(master_mtu_i) && $stable(slave_mtu_i)
        |=> !tx_err_o ##1 tx_busy_o)
        else $error("legal frame not taken");
    a_err_one_cycle: assert property (tx_err_o |=> !tx_err_o)
        else $error("refusal pulse too long");
    a_done_then_idle: assert property (tx_done_o |-> tx_busy_o ##1 !tx_busy_o)
        else $error("busy does not end after done");
    a_done_after_cs: assert property (tx_done_o |-> spi_cs_n_i)
        else $error("done inside an access");
    a_fill_when_idle: assert property (!tx_busy_o && !spi_cs_n_i |-> spi_miso_o)
        else $error("miso not filler while idle");
    a_rx_exclusive: assert property (!(rx_done_o && rx_err_o))
        else $error("frame both good and bad");
    a_rx_single: assert property (rx_done_o |=> !rx_done_o)
        else $error("receive pulse too long");
    c_req: cover property ($fell(spi_req_o));
    c_tx_done: cover property (tx_done_o);
    c_rx_done: cover property (rx_done_o);
    c_rx_err: cover property (rx_err_o);
endmodule
bind sflt_top sflt_top_chk u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_n_o(spi_miso_oe_n_o),
    .spi_req_o(spi_req_o), .master_mtu_i(master_mtu_i),
    .slave_mtu_i(slave_mtu_i), .tx_start_i(tx_start_i),
    .tx_len_i(tx_len_i), .tx_busy_o(tx_busy_o), .tx_err_o(tx_err_o),
    .tx_done_o(tx_done_o), .rx_done_o(rx_done_o), .rx_err_o(rx_err_o)
);
`default_nettype wire

// *** testbench/sflt_spi_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module sflt_spi_master
(
    output logic spi_clk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i
);
    logic [7:0] tx_buf [0:31];
    logic [7:0] rx_buf [0:31];
    initial
    begin
        spi_clk_o = 1'b0;
        spi_mosi_o = 1'b0;
        // Raised after time zero so the link side sees a real rising edge.
        #1 spi_cs_n_o = 1'b1;
    end
    // Mode 0 at a 12 ns period; the clock stands still between accesses.
    task automatic access(input int n);
        spi_cs_n_o = 1'b0;
        #30;
        for (int i = 0; i < n; i++)
        begin
            for (int b = 7; b >= 0; b--)
            begin
                spi_mosi_o = tx_buf[i][b];
                #6 spi_clk_o = 1'b1;
                rx_buf[i][b] = spi_miso_i;
                #6 spi_clk_o = 1'b0;
            end
        end
        #30;
        spi_cs_n_o = 1'b1;
        // A released line must not keep showing its last bit.
        spi_mosi_o = ~spi_mosi_o;
        #300;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk_i = 1'b1;
    logic rst_i = 1'b0;
    logic spi_clk, spi_cs_n, spi_mosi, spi_miso, oe_n, req, req_d;
    logic [7:0] m_mtu = 8'h10;
    logic [7:0] s_mtu = 8'h14;
    logic tx_start = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_len = 8'h00;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data, rx_len;
    logic busy, txe, txd, rxd, rxe;
    int errors = 0;
    int num_checks = 0;
    int n_rxd = 0, n_rxe = 0, n_txd = 0, n_txe = 0, n_req = 0;
    logic [7:0] fr [$];
    always #10 ref_clk_i = ~ref_clk_i;
    sflt_spi_master M (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n),
        .spi_mosi_o(spi_mosi), .spi_miso_i(spi_miso));
    sflt_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi),
        .spi_miso_o(spi_miso), .spi_miso_oe_n_o(oe_n), .spi_req_o(req),
        .master_mtu_i(m_mtu), .slave_mtu_i(s_mtu), .tx_start_i(tx_start),
        .tx_len_i(tx_len), .tx_byte_valid_i(tx_valid), .tx_byte_i(tx_byte),
        .tx_busy_o(busy), .tx_err_o(txe), .tx_done_o(txd),
        .rx_rd_addr_i(rd_addr), .rx_rd_data_o(rd_data), .rx_done_o(rxd),
        .rx_err_o(rxe), .rx_len_o(rx_len));
    always @(posedge ref_clk_i)
    begin
        req_d <= req;
        n_rxd <= n_rxd + (rxd === 1'b1);
        n_rxe <= n_rxe + (rxe === 1'b1);
        n_txd <= n_txd + (txd === 1'b1);
        n_txe <= n_txe + (txe === 1'b1);
        n_req <= n_req + (req === 1'b1 && req_d !== 1'b1);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic make_frame(input logic [7:0] len, input logic [7:0] s);
        logic [15:0] c;
        fr = {len};
        for (int i = 0; i < len; i++)
            fr.push_back(s + 8'(i));
        c = 16'hffff;
        foreach (fr[i])
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[i][b]) ? 16'h1021 : 16'h0);
        fr.push_back(c[15:8]);
        fr.push_back(c[7:0]);
    endtask
    task automatic m_send(input int n);
        for (int i = 0; i < n; i++)
            M.tx_buf[i] = (i < fr.size()) ? fr[i] : 8'hff;
        M.access(n);
    endtask
    task automatic slave_tx(input logic [7:0] len, input logic [7:0] s);
        int r;
        make_frame(len, s);
        r = n_req;
        tx_start = 1'b1;
        tx_len = len;
        @(negedge ref_clk_i);
        tx_start = 1'b0;
        for (int i = 1; i <= len; i++)
        begin
            tx_valid = 1'b1;
            tx_byte = fr[i];
            @(negedge ref_clk_i);
        end
        tx_valid = 1'b0;
        check(busy, 1, "frame not taken");
        for (int k = 0; k < 400 && n_req == r; k++)
            @(negedge ref_clk_i);
        check(16'(n_req - r), 1, "no access request");
    endtask
    task automatic slave_read(input int n, input int off);
        logic [7:0] e;
        for (int i = 0; i < n; i++)
            M.tx_buf[i] = 8'hff;
        M.access(n);
        check(oe_n, 1'b1, "miso driven while deselected");
        for (int i = 0; i < n; i++)
        begin
            e = (off + i < fr.size()) ? fr[off + i] : 8'hff;
            check(M.rx_buf[i], e, "miso byte");
        end
    endtask
    task automatic start_err(input logic [7:0] len);
        int d;
        d = n_txe;
        tx_start = 1'b1;
        tx_len = len;
        @(negedge ref_clk_i);
        tx_start = 1'b0;
        wait_cyc(2);
        check(16'(n_txe - d), 1, "start not refused");
        check(busy, 0, "refused start busy");
    endtask
    task automatic t_master_rx();
        int d;
        d = n_rxd;
        make_frame(8'h02, 8'h40);
        m_send(8);
        wait_cyc(10);
        check(16'(n_rxd - d), 1, "frame not received");
        check(rx_len, 8'h02, "rx length");
        rd_addr = 8'h01;
        wait_cyc(2);
        check(rd_data, 8'h41, "rx payload");
        for (int i = 0; i < 8; i++)
            check(M.rx_buf[i], 8'hff, "slave filler");
        $display("test master_rx done");
    endtask
    task automatic t_bad_crc();
        int d, g;
        d = n_rxe;
        g = n_rxd;
        make_frame(8'h03, 8'h10);
        fr[4] = fr[4] ^ 8'h01;
        m_send(6);
        wait_cyc(10);
        check(16'(n_rxe - d), 1, "bad frame not flagged");
        check(16'(n_rxd - g), 0, "bad frame delivered");
        $display("test bad_crc done");
    endtask
    task automatic t_slave_one();
        int d;
        slave_tx(8'h03, 8'h20);
        d = n_txd;
        slave_read(9, 0);
        wait_cyc(10);
        check(16'(n_txd - d), 1, "no done");
        check(busy, 0, "still busy");
        $display("test slave_one done");
    endtask
    task automatic t_slave_split();
        int d;
        slave_tx(8'h04, 8'h30);
        d = n_txd;
        slave_read(3, 0);
        wait_cyc(10);
        check(16'(n_txd - d), 0, "done too early");
        check(busy, 1, "frame dropped");
        slave_read(4, 3);
        wait_cyc(10);
        check(16'(n_txd - d), 1, "no done after resume");
        $display("test slave_split done");
    endtask
    task automatic t_mtu();
        int d;
        start_err(8'h0e);
        start_err(8'h00);
        m_mtu = 8'h14;
        s_mtu = 8'h10;
        wait_cyc(2);
        start_err(8'h0e);
        slave_tx(8'h0d, 8'h60);
        d = n_txd;
        slave_read(16, 0);
        wait_cyc(10);
        check(16'(n_txd - d), 1, "full mtu frame not done");
        $display("test mtu done");
    endtask
    initial
    begin
        #400000;
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end
    initial
    begin
        // Reset rises after time zero so the link flops see its edge.
        @(negedge ref_clk_i);
        rst_i = 1'b1;
        repeat (12) @(negedge ref_clk_i);
        rst_i = 1'b0;
        wait_cyc(6);
        t_master_rx();
        t_bad_crc();
        t_slave_one();
        t_slave_split();
        t_mtu();
        final_report();
    end
endmodule
`default_nettype wire
